// File: ifn_datapath.sv
// Purpose: four-channel interpolation chain, two oscillator-driven complex
//          mixers and an inverse-sinc stage, the mixers and inverse-sinc at the converter rate
// Assumes: upstream presents a sample on every channel while in_ready is
//          high; the output stream advances every clock
// Notes:   channels a,b form pair 1 (I,Q); c,d form pair 2 (I,Q)
`timescale 1ns/1ps

module ifn_datapath (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] interp_sel,
    input wire logic signed [ifn_pkg::SMP_W-1:0] in_a,
    input wire logic signed [ifn_pkg::SMP_W-1:0] in_b,
    input wire logic signed [ifn_pkg::SMP_W-1:0] in_c,
    input wire logic signed [ifn_pkg::SMP_W-1:0] in_d,
    output logic in_ready,
    input wire logic mix_en,
    input wire logic mixer_gain,
    input wire logic [ifn_pkg::NCO_W-1:0] freq_word_pair1,
    input wire logic [ifn_pkg::NCO_W-1:0] freq_word_pair2,
    input wire logic [ifn_pkg::OFF_W-1:0] phase_offset_pair1,
    input wire logic [ifn_pkg::OFF_W-1:0] phase_offset_pair2,
    input wire logic [3:0] osc_sync_select,
    input wire logic [3:0] sync_src,
    input wire logic isinc_en,
    output logic signed [ifn_pkg::SMP_W-1:0] out_a,
    output logic signed [ifn_pkg::SMP_W-1:0] out_b,
    output logic signed [ifn_pkg::SMP_W-1:0] out_c,
    output logic signed [ifn_pkg::SMP_W-1:0] out_d
);
    import ifn_pkg::*;

    logic [3:0] cnt_reg; // free-running rate counter
    logic [3:0] cnt_next;
    logic stb [HB_N]; // stage produces an output this cycle
    logic ph [HB_N]; // 0: take new input, 1: emit held sample
    logic signed [SMP_W-1:0] in_vec [4];
    logic signed [SMP_W-1:0] st_out [HB_N][4]; // per-stage outputs
    logic signed [SMP_W-1:0] filt_reg [4];
    logic signed [SMP_W-1:0] filt_next [4];
    logic signed [SMP_W-1:0] mix_reg [4];
    logic signed [SMP_W-1:0] mix_next [4];
    logic signed [SMP_W-1:0] isd_reg [4][IS_TAPS-1]; // inverse-sinc taps
    logic signed [SMP_W-1:0] isd_next [4][IS_TAPS-1];
    logic signed [SMP_W-1:0] out_reg [4];
    logic signed [SMP_W-1:0] out_next [4];
    logic [NCO_W-1:0] acc_reg [2];
    logic [NCO_W-1:0] acc_next [2];
    logic [NCO_W-1:0] freq [2];
    logic [OFF_W-1:0] poff [2];
    logic signed [SMP_W-1:0] sin_v [2];
    logic signed [SMP_W-1:0] cos_v [2];
    logic sync_hit;

    assign in_vec = '{in_a, in_b, in_c, in_d};
    assign freq = '{freq_word_pair1, freq_word_pair2};
    assign poff = '{phase_offset_pair1, phase_offset_pair2};

    // stage k runs at clk / 2^(sel-k); unused stages stay idle
    always_comb begin
        cnt_next = cnt_reg + 4'h1;
        for (int k = 0; k < HB_N; k++) begin
            logic [3:0] mask;
            logic [1:0] pos;
            pos = 2'(interp_sel - 2'(k));
            mask = 4'((5'h1 << pos) - 5'h1);
            stb[k] = (k <= int'(interp_sel)) && ((cnt_reg & mask) == mask);
            ph[k] = cnt_reg[pos];
        end
        in_ready = stb[0] && !ph[0];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // each half-band stage doubles the rate: the even phase is the
    // symmetric sum of nonzero taps, the odd phase the held sample
    for (genvar k = 0; k < HB_N; k++) begin : g_hb
        localparam int L = HB_L[k];
        logic signed [SMP_W-1:0] dly [4][2*L];
        logic signed [SMP_W-1:0] dly_n [4][2*L];
        logic signed [SMP_W-1:0] o_reg [4];
        logic signed [SMP_W-1:0] o_next [4];
        logic signed [SMP_W-1:0] src [4];

        if (k == 0) begin : g_src0
            assign src = in_vec;
        end else begin : g_srcn
            assign src = st_out[k-1];
        end
        assign st_out[k] = o_reg;

        always_comb begin
            logic signed [ACC_W-1:0] acc;
            acc = '0;
            dly_n = dly;
            o_next = o_reg;
            for (int c = 0; c < 4; c++) begin
                acc = '0;
                if (stb[k] && !ph[k]) begin
                    for (int m = 0; m < L; m++) begin
                        acc = acc + 40'(HB_COEF[k][m]) *
                            (40'(dly[c][L-1-m]) + 40'(dly[c][L+m]));
                    end
                    o_next[c] = sat16(acc >>> HB_SHIFT[k]);
                    for (int m = 2*L-1; m > 0; m--) begin
                        dly_n[c][m] = dly[c][m-1];
                    end
                    dly_n[c][0] = src[c];
                end else if (stb[k]) begin
                    o_next[c] = dly[c][L];
                end
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                dly <= '{default: '0};
                o_reg <= '{default: '0};
            end else begin
                dly <= dly_n;
                o_reg <= o_next;
            end
        end
    end

    // oscillators: one per pair, run independently, cleared by sync
    assign sync_hit = |(sync_src & osc_sync_select);

    for (genvar p = 0; p < 2; p++) begin : g_nco
        logic [ROM_AW-1:0] rom_ph;
        logic [OFF_W-1:0] ph_sum;
        assign ph_sum = acc_reg[p][NCO_W-1 -: OFF_W] + poff[p];
        assign rom_ph = ph_sum[OFF_W-1 -: ROM_AW];
        always_comb begin
            acc_next[p] = acc_reg[p] + freq[p];
            if (sync_hit) begin
                acc_next[p] = '0;
            end
        end
        ifn_sin_rom u_rom (
            .clk(clk),
            .rst_n(rst_n),
            .phase(rom_ph),
            .sin_out(sin_v[p]),
            .cos_out(cos_v[p])
        );
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= '{default: '0};
        end else begin
            acc_reg <= acc_next;
        end
    end

    // last active stage feeds the mixers; complex multiply per pair
    always_comb begin
        logic signed [ACC_W-1:0] pi;
        logic signed [ACC_W-1:0] pq;
        logic [4:0] sh;
        pi = '0;
        pq = '0;
        sh = 5'(MIX_SHIFT) - 5'(mixer_gain);
        filt_next = st_out[interp_sel];
        mix_next = filt_reg;
        for (int p = 0; p < 2; p++) begin
            pi = 40'(filt_reg[2*p]) * 40'(cos_v[p]) -
                 40'(filt_reg[2*p+1]) * 40'(sin_v[p]);
            pq = 40'(filt_reg[2*p]) * 40'(sin_v[p]) +
                 40'(filt_reg[2*p+1]) * 40'(cos_v[p]);
            if (mix_en) begin
                mix_next[2*p] = sat16(pi >>> sh);
                mix_next[2*p+1] = sat16(pq >>> sh);
            end
        end
    end

    // inverse-sinc at full rate; gain above one, so input needs headroom
    always_comb begin
        logic signed [ACC_W-1:0] s;
        s = '0;
        out_next = mix_reg;
        for (int c = 0; c < 4; c++) begin
            isd_next[c][0] = mix_reg[c];
            for (int m = 1; m < IS_TAPS-1; m++) begin
                isd_next[c][m] = isd_reg[c][m-1];
            end
            s = 40'(IS_CENTRE) * 40'(isd_reg[c][3]);
            for (int m = 0; m < 4; m++) begin
                s = s + 40'(IS_COEF[m]) * (40'(m == 0 ? mix_reg[c] :
                    isd_reg[c][m-1]) + 40'(isd_reg[c][7-m]));
            end
            if (isinc_en) begin
                out_next[c] = sat16(s >>> IS_SHIFT);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_reg <= '{default: '0};
            mix_reg <= '{default: '0};
            isd_reg <= '{default: '0};
            out_reg <= '{default: '0};
        end else begin
            filt_reg <= filt_next;
            mix_reg <= mix_next;
            isd_reg <= isd_next;
            out_reg <= out_next;
        end
    end

    assign out_a = out_reg[0];
    assign out_b = out_reg[1];
    assign out_c = out_reg[2];
    assign out_d = out_reg[3];

    // checks on accumulators, rates and bypass paths
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_acc_pair1;
        !sync_hit |=> acc_reg[0] == $past(acc_reg[0]) + $past(freq[0]);
    endproperty
    a_acc_pair1: assert property (p_acc_pair1)
        else $error("pair 1 accumulator did not add its word");
    property p_acc_pair2;
        !sync_hit |=> acc_reg[1] == $past(acc_reg[1]) + $past(freq[1]);
    endproperty
    a_acc_pair2: assert property (p_acc_pair2)
        else $error("pair 2 accumulator not independent");
    property p_sync_pair1;
        sync_hit |=> acc_reg[0] == '0;
    endproperty
    a_sync_pair1: assert property (p_sync_pair1)
        else $error("sync did not clear pair 1 accumulator");
    property p_sync_pair2;
        sync_hit |=> acc_reg[1] == '0;
    endproperty
    a_sync_pair2: assert property (p_sync_pair2)
        else $error("sync did not clear pair 2 accumulator");
    property p_rate_x2;
        (in_ready && interp_sel == 2'h0) ##1 (interp_sel == 2'h0) |->
            !in_ready ##1 (in_ready || interp_sel != 2'h0);
    endproperty
    a_rate_x2: assert property (p_rate_x2)
        else $error("2x input strobe spacing wrong");
    property p_rate_x4;
        (in_ready && interp_sel == 2'h1) |=>
            (!in_ready || interp_sel != 2'h1) [*3] ##1
            (in_ready || interp_sel != 2'h1);
    endproperty
    a_rate_x4: assert property (p_rate_x4)
        else $error("4x input strobe spacing wrong");
    property p_isinc_bypass;
        !isinc_en |=> out_reg[0] == $past(mix_reg[0]);
    endproperty
    a_isinc_bypass: assert property (p_isinc_bypass)
        else $error("inverse-sinc bypass altered sample");
    property p_mix_bypass;
        !mix_en |=> mix_reg[3] == $past(filt_reg[3]);
    endproperty
    a_mix_bypass: assert property (p_mix_bypass)
        else $error("mixer bypass altered sample");

    c_sync: cover property (sync_hit ##1 !sync_hit);
    c_x16: cover property (in_ready && interp_sel == 2'h3);
    c_mix_half: cover property (mix_en && !mixer_gain);
    c_isinc: cover property (isinc_en && mix_en);
endmodule

// File: ifn_pkg.sv
// Purpose: shared constants for the interpolation, oscillator and mixer
//          datapath, plus the quarter-wave sine table used by the oscillators
// Assumes: one clock, 16-bit signed samples, table built at elaboration
// Notes:   the sine table module is a small read-only memory with registered
//          read data; both sine and cosine are read in the same cycle
`timescale 1ns/1ps

package ifn_pkg;
    // sample and arithmetic widths
    localparam int SMP_W = 16;
    localparam int ACC_W = 40;
    localparam int NCO_W = 32;
    localparam int OFF_W = 16;
    localparam int ROM_AW = 10;
    localparam logic signed [ACC_W-1:0] SMP_MAX = 40'sh00_0000_7fff;
    localparam logic signed [ACC_W-1:0] SMP_MIN = -40'sh00_0000_8000;
    // half-band stages: pair coefficients from the centre outward
    localparam int HB_N = 4;
    localparam int HB_MAXL = 15;
    localparam int HB_L [HB_N] = '{15, 6, 3, 3};
    // centre taps 65536, 16384, 2048, 256 become these normalising shifts
    localparam int HB_SHIFT [HB_N] = '{16, 14, 11, 8};
    localparam int HB_COEF [HB_N][HB_MAXL] = '{
        '{41527, -13334, 7420, -4729, 3152, -2119, 1409, -914, 572, -342,
          192, -100, 47, -19, 6},
        '{10141, -2691, 1006, -336, 84, -12, 0, 0, 0, 0, 0, 0, 0, 0, 0},
        '{1209, -214, 29, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
        '{150, -25, 3, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0}};
    // inverse-sinc outer taps, centre tap, and shift (tap sum is 512)
    localparam int IS_TAPS = 9;
    localparam int IS_COEF [4] = '{1, -4, 13, -50};
    localparam int IS_CENTRE = 592;
    localparam int IS_SHIFT = 9;
    // mixer product shift: 16 halves the output, 15 leaves it unscaled
    localparam int MIX_SHIFT = 16;
    localparam int SIN_AMP = 32767;
    localparam int QTR_N = 256;
    localparam logic [ROM_AW-1:0] QTR_STEP = 10'h100;

    // clip to the sample range instead of wrapping
    function automatic logic signed [SMP_W-1:0] sat16(
        input logic signed [ACC_W-1:0] v);
        if (v > SMP_MAX) begin
            return 16'sh7fff;
        end else if (v < SMP_MIN) begin
            return -16'sh8000;
        end
        return v[SMP_W-1:0];
    endfunction
endpackage

// quarter-wave sine memory, sine and cosine read together
module ifn_sin_rom (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ifn_pkg::ROM_AW-1:0] phase,
    output logic signed [ifn_pkg::SMP_W-1:0] sin_out,
    output logic signed [ifn_pkg::SMP_W-1:0] cos_out
);
    import ifn_pkg::*;

    // table entry at the middle of each step keeps the quarter symmetric
    function automatic logic signed [SMP_W-1:0] qval(input int i);
        real a;
        a = 1.5707963267948966 * (real'(i) + 0.5) / real'(QTR_N);
        return 16'(int'(real'(SIN_AMP) * $sin(a)));
    endfunction

    logic signed [SMP_W-1:0] tab [QTR_N]; // constant table
    logic [ROM_AW-1:0] cph; // cosine is sine a quarter turn ahead
    logic signed [SMP_W-1:0] sin_next;
    logic signed [SMP_W-1:0] cos_next;
    logic signed [SMP_W-1:0] sin_reg;
    logic signed [SMP_W-1:0] cos_reg;

    for (genvar i = 0; i < QTR_N; i++) begin : g_tab
        assign tab[i] = qval(i);
    end

    // fold the full turn onto the quarter table
    always_comb begin
        logic [7:0] si;
        logic [7:0] ci;
        si = phase[8] ? ~phase[7:0] : phase[7:0];
        cph = phase + QTR_STEP;
        ci = cph[8] ? ~cph[7:0] : cph[7:0];
        sin_next = phase[9] ? -tab[si] : tab[si];
        cos_next = cph[9] ? -tab[ci] : tab[ci];
    end

    // read data leave from a register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sin_reg <= '0;
            cos_reg <= '0;
        end else begin
            sin_reg <= sin_next;
            cos_reg <= cos_next;
        end
    end

    assign sin_out = sin_reg;
    assign cos_out = cos_reg;
endmodule

// File: ifn_feeder.sv
// Purpose: upstream sample source standing in front of the datapath
// Assumes: the bench holds the wanted levels; lines change at falling edge
// Notes:   outside a request the lines carry junk, never the held level
`timescale 1ns/1ps

module ifn_feeder (
    input wire logic clk,
    input wire logic in_ready,
    input wire logic signed [ifn_pkg::SMP_W-1:0] lvl_a,
    input wire logic signed [ifn_pkg::SMP_W-1:0] lvl_b,
    input wire logic signed [ifn_pkg::SMP_W-1:0] lvl_c,
    input wire logic signed [ifn_pkg::SMP_W-1:0] lvl_d,
    output logic signed [ifn_pkg::SMP_W-1:0] in_a,
    output logic signed [ifn_pkg::SMP_W-1:0] in_b,
    output logic signed [ifn_pkg::SMP_W-1:0] in_c,
    output logic signed [ifn_pkg::SMP_W-1:0] in_d
);
    import ifn_pkg::*;
    // lines stay unknown until the first falling edge, still inside reset,
    // so that a single process drives them
    // levels come already backed off ahead of the inverse-sinc
    // that back-off stands in for the correction gain
    // inverted data when not requested, so a stray capture is visible
    always @(negedge clk) begin
        in_a <= in_ready ? lvl_a : ~lvl_a;
        in_b <= in_ready ? lvl_b : ~lvl_b;
        in_c <= in_ready ? lvl_c : ~lvl_c;
        in_d <= in_ready ? lvl_d : ~lvl_d;
    end
endmodule

// File: ifn_datapath_tb.sv
// Purpose: self-checking bench for the interpolation and mixer datapath
// Assumes: dc levels pass every filter stage with exact unity gain
// Notes:   driver queues expected notes; a monitor compares at the outputs
`timescale 1ns/1ps

module ifn_datapath_tb;
    import ifn_pkg::*;
    typedef struct {
        logic signed [15:0] e [4];
        int tol;
        bit alt;
    } ifn_note_s;
    localparam int CMAX = 32'sh7fff;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] interp_sel = 2'h0;
    logic mix_en = 1'b0;
    logic mixer_gain = 1'b1;
    logic isinc_en = 1'b0;
    logic [31:0] freq1 = 32'h0;
    logic [31:0] freq2 = 32'h0;
    logic [15:0] off1 = 16'h0;
    logic [15:0] off2 = 16'h0;
    logic [3:0] sync_mask = 4'h0;
    logic [3:0] sync_src = 4'h0;
    logic signed [15:0] lvl [4] = '{default: 16'h0};
    logic signed [15:0] din [4];
    logic signed [15:0] dout [4];
    logic signed [15:0] prev [4];
    logic in_ready;
    ifn_note_s notes [$];
    ifn_note_s cur;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    int gap = 0;
    int exp_gap = 0;
    logic [31:0] seed = 32'h25;

    ifn_feeder i_src (.clk(clk), .in_ready(in_ready), .lvl_a(lvl[0]),
        .lvl_b(lvl[1]), .lvl_c(lvl[2]), .lvl_d(lvl[3]), .in_a(din[0]),
        .in_b(din[1]), .in_c(din[2]), .in_d(din[3]));
    ifn_datapath i_dut (.clk(clk), .rst_n(rst_n), .interp_sel(interp_sel),
        .in_a(din[0]), .in_b(din[1]), .in_c(din[2]), .in_d(din[3]),
        .in_ready(in_ready), .mix_en(mix_en), .mixer_gain(mixer_gain),
        .freq_word_pair1(freq1), .freq_word_pair2(freq2),
        .phase_offset_pair1(off1), .phase_offset_pair2(off2),
        .osc_sync_select(sync_mask), .sync_src(sync_src),
        .isinc_en(isinc_en), .out_a(dout[0]), .out_b(dout[1]),
        .out_c(dout[2]), .out_d(dout[3]));

    // 10 MHz clock
    always #50 clk = ~clk;

    // only comparison point; unknown values always count as wrong
    task automatic check(input string what, input logic signed [15:0] seen,
            input logic signed [15:0] exp, input int tol);
        logic signed [16:0] d;
        d = seen - exp;
        comparisons++;
        if (^seen === 1'bx || d > tol || d < -tol) begin
            n_fail++;
            $display("wrong value %s: expected %0d, seen %0d", what, exp,
                seen);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // xorshift levels kept within +-4096 so the mixer never clips
    function automatic logic signed [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return {{3{seed[12]}}, seed[12:0]};
    endfunction

    // oscillator term on the 10-bit phase grid, valued at each step's
    // middle, so a quarter turn still leaves a small cosine term
    function automatic int trig(input logic [15:0] off, input bit want_sin);
        real a;
        a = 6.283185307179586 * (real'(off[15:6]) + 0.5) / 1024.0;
        return int'(32767.0 * (want_sin ? $sin(a) : $cos(a)));
    endfunction

    // i*c - q*s scaled by the gain bit, clipped like the hardware should
    function automatic logic signed [15:0] mx(input logic signed [15:0] i,
            input logic signed [15:0] q, input logic [15:0] off);
        logic signed [47:0] p;
        p = 48'(i) * trig(off, 1'b0) - 48'(q) * trig(off, 1'b1);
        p = p >>> (16 - mixer_gain);
        return p > CMAX ? 16'sh7fff : p < -CMAX - 1 ? -16'sh8000 : p[15:0];
    endfunction

    // let the pipeline settle, then queue one note
    task automatic note(input logic signed [15:0] a, input logic signed
            [15:0] b, input logic signed [15:0] c, input logic signed [15:0] d,
            input int tol, input bit alt, input int wait_n);
        repeat (wait_n) @(negedge clk);
        notes.push_back('{'{a, b, c, d}, tol, alt});
        @(negedge clk);
    endtask

    // pair 1 at one phase, pair 2 at another, both from a fixed oscillator
    task automatic mix_case(input logic [15:0] o1, input logic [15:0] o2);
        off1 = o1;
        off2 = o2;
        note(mx(lvl[0], lvl[1], o1), mx(lvl[1], -lvl[0], o1),
            mx(lvl[2], lvl[3], o2), mx(lvl[3], -lvl[2], o2), 4, 0,
            300);
    endtask

    // monitor: request spacing and the oldest note against the outputs
    always @(posedge clk) begin
        if (in_ready) begin
            if (exp_gap > 0) begin
                check("ready spacing", 16'(gap), 16'(exp_gap), 0);
            end
            gap <= 1;
        end else begin
            gap <= gap + 1;
        end
        if (notes.size() > 0) begin
            cur = notes.pop_front();
            for (int k = 0; k < 4; k++) begin
                if (cur.alt && k < 2) begin
                    check("opposite sign sum", dout[k] + prev[k], 16'h0,
                        cur.tol);
                end else begin
                    check($sformatf("out %0d", k), dout[k], cur.e[k],
                        cur.tol);
                end
            end
        end
        prev <= dout;
    end

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        note(16'h0, 16'h0, 16'h0, 16'h0, 0, 0, 5);
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        // dc through every interpolation setting, inverse-sinc toggled
        for (int s = 0; s < 4; s++) begin
            interp_sel = 2'(s);
            isinc_en = s[0];
            exp_gap = 0;
            foreach (lvl[k]) lvl[k] = rnd();
            repeat (40) @(negedge clk);
            exp_gap = 2 << s;
            note(lvl[0], lvl[1], lvl[2], lvl[3], 0, 0, 1200);
        end
        interp_sel = 2'h0;
        exp_gap = 0;
        mix_en = 1'b1;
        repeat (40) @(negedge clk);
        exp_gap = 2;
        // quarter-turn offsets, both gain settings
        for (int g = 0; g < 2; g++) begin
            mixer_gain = g[0];
            isinc_en = g[0];
            foreach (lvl[k]) lvl[k] = rnd();
            mix_case(16'h0, 16'h4000);
            mix_case(16'h8000, 16'hc000);
        end
        // full scale at 45 degrees drives the sum past the range when mixer_gain is 1
        isinc_en = 1'b0;
        for (int g = 0; g < 4; g++) begin
            mixer_gain = g[0];
            foreach (lvl[k]) lvl[k] = g[1] ? -16'sh7fff : 16'sh7fff;
            mix_case(16'h2000, 16'h2000);
        end
        // held sync pins oscillator 1 at zero phase despite its word
        mixer_gain = 1'b1;
        foreach (lvl[k]) lvl[k] = rnd();
        freq1 = 32'h8000_0000;
        sync_mask = 4'h2;
        sync_src = 4'h2;
        mix_case(16'h0, 16'h4000);
        // unselected source: half-turn steps flip pair 1 every clock
        sync_src = 4'h1;
        note(16'h0, 16'h0, mx(lvl[2], lvl[3], off2),
            mx(lvl[3], -lvl[2], off2), 4, 1, 300);
        wrap_up();
    end
endmodule
